// >>> hw/capture_pkg.sv
// Shared constants and types of the eight-channel input capture unit.
package capture_pkg;
    // Unit geometry.
    localparam int NUM_CHANNELS = 8;
    localparam int CHAN_W = 3;
    localparam int TIMER_W = 16;
    localparam int CTRL_W = 16;
    localparam int FIFO_DEPTH = 4;
    localparam int FIFO_CNT_W = 3;
    localparam int FIFO_IDX_W = 2;
    // Field positions inside the channel control word.
    localparam int MODE_LSB = 0;
    localparam int MODE_MSB = 2;
    localparam int BNE_BIT = 3;
    localparam int OVF_BIT = 4;
    localparam int EPI_LSB = 5;
    localparam int EPI_MSB = 6;
    localparam int TSEL_BIT = 7;
    localparam int SIDL_BIT = 13;
    // Prescaler terminal counts and reset values.
    localparam logic [3:0] PRE_RESET = 4'h0;
    localparam logic [3:0] PRE4_LAST = 4'h3;
    localparam logic [3:0] PRE16_LAST = 4'hF;
    localparam logic [1:0] EPI_RESET = 2'h0;
    localparam logic [TIMER_W-1:0] WORD_RESET = 16'h0000;
    // Capture condition encodings of the mode field.
    typedef enum logic [2:0] {
        MODE_OFF = 3'h0,
        MODE_EVERY_EDGE = 3'h1,
        MODE_FALL = 3'h2,
        MODE_RISE = 3'h3,
        MODE_RISE4 = 3'h4,
        MODE_RISE16 = 3'h5,
        MODE_UNUSED = 3'h6,
        MODE_WAKE_RISE = 3'h7
    } capture_mode_type;
endpackage

// >>> hw/capture_fifo.sv
// Four-word shifting capture buffer with a registered not-empty flag.
module capture_fifo (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic push_i,
    input wire logic [capture_pkg::TIMER_W-1:0] push_data_i,
    input wire logic pop_i,
    output logic [capture_pkg::TIMER_W-1:0] head_o,
    output logic full_o,
    output logic empty_o,
    output logic not_empty_o
);
    import capture_pkg::*;

    logic [TIMER_W-1:0] mem_q [FIFO_DEPTH];
    logic [TIMER_W-1:0] mem_d [FIFO_DEPTH];
    logic [FIFO_CNT_W-1:0] cnt_q;
    logic [FIFO_CNT_W-1:0] cnt_d;
    logic not_empty_q;
    logic [FIFO_IDX_W-1:0] wr_idx;
    wire pop_ok;
    wire push_ok;

    // A pop of an empty buffer changes nothing; a push into a full one is refused unless a pop frees a slot in the same cycle.
    assign full_o = (cnt_q == FIFO_CNT_W'(FIFO_DEPTH));
    assign empty_o = ~not_empty_q;
    assign not_empty_o = not_empty_q;
    assign pop_ok = pop_i & not_empty_q;
    assign push_ok = push_i & (~full_o | pop_ok);
    assign head_o = mem_q[0];

    // Oldest word sits at slot zero; a pop moves every other word forward.
    always_comb begin
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            mem_d[i] = mem_q[i];
        end
        wr_idx = pop_ok ? FIFO_IDX_W'(cnt_q - 3'h1) : FIFO_IDX_W'(cnt_q);
        if (pop_ok) begin
            for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
                mem_d[i] = mem_q[i + 1];
            end
        end
        if (push_ok) begin
            mem_d[wr_idx] = push_data_i;
        end
        cnt_d = cnt_q + FIFO_CNT_W'(push_ok) - FIFO_CNT_W'(pop_ok);
    end

    // Storage words carry no reset; only the fill count and not-empty flag are control state.
    always_ff @(posedge mclk_i) begin
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            mem_q[i] <= mem_d[i];
        end
    end

    // Fill count and not-empty flag update together.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cnt_q <= 3'h0;
            not_empty_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            not_empty_q <= (cnt_d != 3'h0);
        end
    end
endmodule

// >>> hw/read_skid.sv
// Two-entry buffer between the read port and the receiver of the words.
module read_skid #(
    parameter int DW = 19
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [DW-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [DW-1:0] out_data_o
);
    logic out_valid_q;
    logic free_q;
    logic [DW-1:0] out_q;
    logic [DW-1:0] spare_q;

    assign in_ready_o = free_q;
    assign out_valid_o = out_valid_q;
    assign out_data_o = out_q;

    // The spare slot catches the word accepted while the receiver stalls.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            out_valid_q <= 1'b0;
            free_q <= 1'b1;
            out_q <= '0;
            spare_q <= '0;
        end else if (!out_valid_q || out_ready_i) begin
            if (!free_q) begin
                out_q <= spare_q;
                out_valid_q <= 1'b1;
                free_q <= 1'b1;
            end else begin
                out_valid_q <= in_valid_i;
                if (in_valid_i) begin
                    out_q <= in_data_i;
                end
            end
        end else if (in_valid_i && free_q) begin
            spare_q <= in_data_i;
            free_q <= 1'b0;
        end
    end
endmodule

// >>> hw/input_capture_channels.sv
// Eight-channel input capture unit with per-channel buffers and wake logic.
// What this block does
// - Eight independent channels, each fully equipped.
// - Mode field picks the edge capture condition.
// - Switching a channel off clears its prescaler.
// - Any reset clears every prescaler counter.
// - Each channel buffers four 16-bit captures.
// - Not-empty set on capture, cleared when drained.
// - Read returns oldest word, others move forward.
// - Fifth capture into full buffer sets overflow.
// - After overflow, store nothing until buffer drained.
// - Select bit picks timer; second is default.
// - Every-edge mode flags each edge, never overflows.
// - Capture in idle or sleep wakes, if enabled.
// - Mode 111 wakes even with timer stopped.
// - Sleep: only mode 111 rising edge interrupt.
// - Two-bit field sets events per interrupt flag.
// - Idle keeps full function if timer on, no stop.
// - Idle with mode 111: pin is interrupt only.
module input_capture_channels (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [capture_pkg::NUM_CHANNELS-1:0] cap_pin_i,
    input wire logic [capture_pkg::NUM_CHANNELS-1:0][capture_pkg::CTRL_W-1:0]
        channel_control_word_i,
    input wire logic [capture_pkg::TIMER_W-1:0] first_shared_timer_i,
    input wire logic [capture_pkg::TIMER_W-1:0] second_shared_timer_i,
    input wire logic first_timer_on_i,
    input wire logic second_timer_on_i,
    input wire logic cpu_idle_i,
    input wire logic cpu_sleep_i,
    input wire logic [capture_pkg::NUM_CHANNELS-1:0] channel_interrupt_enable_i,
    input wire logic [capture_pkg::NUM_CHANNELS-1:0] event_flag_clr_i,
    input wire logic [capture_pkg::NUM_CHANNELS-1:0] overflow_clr_i,
    input wire logic rd_valid_i,
    input wire logic [capture_pkg::CHAN_W-1:0] rd_chan_i,
    output logic rd_ready_o,
    output logic rd_data_valid_o,
    output logic [capture_pkg::TIMER_W-1:0] rd_data_o,
    output logic [capture_pkg::CHAN_W-1:0] rd_data_chan_o,
    input wire logic rd_data_ready_i,
    output logic [capture_pkg::NUM_CHANNELS-1:0] buffer_not_empty_flag_o,
    output logic [capture_pkg::NUM_CHANNELS-1:0] capture_overflow_flag_o,
    output logic [capture_pkg::NUM_CHANNELS-1:0] channel_event_flag_o,
    output logic [capture_pkg::NUM_CHANNELS-1:0][capture_pkg::CTRL_W-1:0]
        channel_status_word_o,
    output logic wake_o
);
    import capture_pkg::*;

    localparam int SKID_W = TIMER_W + CHAN_W;

    logic [TIMER_W-1:0] head [NUM_CHANNELS];
    logic [NUM_CHANNELS-1:0] pop_vec;
    logic [NUM_CHANNELS-1:0] wake_vec;
    logic [NUM_CHANNELS-1:0] ovf_vec;
    logic [NUM_CHANNELS-1:0] evf_vec;
    logic [NUM_CHANNELS-1:0][CTRL_W-1:0] status_d;
    logic wake_q;
    logic skid_ready;
    logic [SKID_W-1:0] skid_out;
    wire rd_take;
    wire [TIMER_W-1:0] rd_word;

    // A read request is taken only while the output buffer has room.
    assign rd_take = rd_valid_i & skid_ready;
    assign rd_word = head[rd_chan_i];
    assign rd_ready_o = skid_ready;
    assign rd_data_o = skid_out[TIMER_W-1:0];
    assign rd_data_chan_o = skid_out[SKID_W-1:TIMER_W];
    assign capture_overflow_flag_o = ovf_vec;
    assign channel_event_flag_o = evf_vec;
    assign wake_o = wake_q;

    // Per-channel logic: one copy for each capture pin.
    for (genvar k = 0; k < NUM_CHANNELS; k++) begin : g_ch
        logic [2:0] sync_q;
        logic level_q;
        logic [3:0] pre_q;
        logic [1:0] epi_q;
        logic ovf_q;
        logic hold_q;
        logic evf_q;
        logic fifo_full;
        logic fifo_empty;
        wire [CTRL_W-1:0] cw;
        wire capture_mode_type mode;
        wire timebase_select_bit;
        wire [1:0] epi_field;
        wire stop_in_idle_bit;
        wire timer_on;
        wire [TIMER_W-1:0] tcount;
        wire settled;
        wire rise;
        wire fall;
        wire full_run;
        wire irq_only;
        wire pre_mode;
        wire pre_last;
        wire qual;
        wire cap_ev;
        wire push;
        wire ovf_ev;
        wire epi_hit;
        wire irq_ev;

        // Control word fields.
        assign cw = channel_control_word_i[k];
        assign mode = capture_mode_type'(cw[MODE_MSB:MODE_LSB]);
        assign timebase_select_bit = cw[TSEL_BIT];
        assign epi_field = cw[EPI_MSB:EPI_LSB];
        assign stop_in_idle_bit = cw[SIDL_BIT];

        // Select bit low picks the second timer, which is the reset default.
        assign timer_on = timebase_select_bit ? first_timer_on_i : second_timer_on_i;
        assign tcount = timebase_select_bit ? first_shared_timer_i
                                            : second_shared_timer_i;

        // An edge counts once the second and third stages agree on a new level.
        assign settled = (sync_q[1] == sync_q[2]);
        assign rise = settled & sync_q[2] & ~level_q;
        assign fall = settled & ~sync_q[2] & level_q;

        // Full function outside sleep; in idle only with timer on and no stop.
        assign full_run = ~cpu_sleep_i
            & (~cpu_idle_i | (timer_on & ~stop_in_idle_bit));
        assign irq_only = (cpu_sleep_i | cpu_idle_i) & (mode == MODE_WAKE_RISE);

        // Prescaled modes fire on the last rising edge of each group.
        assign pre_mode = (mode == MODE_RISE4) | (mode == MODE_RISE16);
        assign pre_last = (mode == MODE_RISE4) ? (pre_q == PRE4_LAST)
                                               : (pre_q == PRE16_LAST);

        // Edge qualification per capture condition.
        assign qual = (mode == MODE_EVERY_EDGE) ? (rise | fall)
                    : (mode == MODE_FALL) ? fall
                    : (mode == MODE_RISE) ? rise
                    : (mode == MODE_RISE4) ? (rise & pre_last)
                    : (mode == MODE_RISE16) ? (rise & pre_last)
                    : (mode == MODE_WAKE_RISE) ? rise
                    : 1'b0;
        assign cap_ev = full_run & ~irq_only & qual;

        // Stores stop after an overflow until the buffer has been drained.
        assign push = cap_ev & ~fifo_full & ~hold_q;
        assign ovf_ev = cap_ev & fifo_full & ~hold_q
            & (mode != MODE_EVERY_EDGE);

        // Every-edge mode ignores the events-per-interrupt count.
        assign epi_hit = (mode == MODE_EVERY_EDGE) | (epi_q == epi_field);
        assign irq_ev = (cap_ev & epi_hit) | (irq_only & rise);
        assign wake_vec[k] = irq_ev & (cpu_idle_i | cpu_sleep_i)
            & channel_interrupt_enable_i[k];
        assign pop_vec[k] = rd_take & (rd_chan_i == CHAN_W'(k));

        // Pin synchroniser and filtered level.
        always_ff @(posedge mclk_i) begin
            if (!rst_n_i) begin
                sync_q <= 3'h0;
                level_q <= 1'b0;
            end else begin
                sync_q <= {sync_q[1:0], cap_pin_i[k]};
                if (settled) begin
                    level_q <= sync_q[2];
                end
            end
        end

        // Capture prescaler cleared by reset and by switching the channel off.
        always_ff @(posedge mclk_i) begin
            if (!rst_n_i) begin
                pre_q <= PRE_RESET;
            end else if (mode == MODE_OFF) begin
                pre_q <= PRE_RESET;
            end else if (full_run && !irq_only && pre_mode && rise) begin
                pre_q <= pre_last ? PRE_RESET : pre_q + 4'h1;
            end
        end

        // Events-per-interrupt counter restarts after each raised flag.
        always_ff @(posedge mclk_i) begin
            if (!rst_n_i || mode == MODE_OFF) begin
                epi_q <= EPI_RESET;
            end else if (cap_ev && mode != MODE_EVERY_EDGE) begin
                epi_q <= epi_hit ? EPI_RESET : epi_q + 2'h1;
            end
        end

        // Sticky flags: a set in the clearing cycle wins over the clear.
        always_ff @(posedge mclk_i) begin
            if (!rst_n_i) begin
                ovf_q <= 1'b0;
                hold_q <= 1'b0;
                evf_q <= 1'b0;
            end else begin
                ovf_q <= ovf_ev | (ovf_q & ~overflow_clr_i[k]);
                hold_q <= ovf_ev | (hold_q & ~fifo_empty);
                evf_q <= irq_ev | (evf_q & ~event_flag_clr_i[k]);
            end
        end
        assign ovf_vec[k] = ovf_q;
        assign evf_vec[k] = evf_q;

        // Status word mirrors the control word with live flags inserted.
        always_comb begin
            status_d[k] = cw;
            status_d[k][OVF_BIT] = ovf_q;
            status_d[k][BNE_BIT] = ~fifo_empty;
        end

        capture_fifo u_fifo (
            .mclk_i(mclk_i),
            .rst_n_i(rst_n_i),
            .push_i(push),
            .push_data_i(tcount),
            .pop_i(pop_vec[k]),
            .head_o(head[k]),
            .full_o(fifo_full),
            .empty_o(fifo_empty),
            .not_empty_o(buffer_not_empty_flag_o[k])
        );
    end

    // Wake request and status words are registered at the outputs.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            wake_q <= 1'b0;
            channel_status_word_o <= '0;
        end else begin
            wake_q <= |wake_vec;
            channel_status_word_o <= status_d;
        end
    end

    // Read words pass through a two-entry buffer so a stall loses nothing.
    read_skid #(
        .DW(SKID_W)
    ) u_skid (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(rd_take),
        .in_ready_o(skid_ready),
        .in_data_i({rd_chan_i, rd_word}),
        .out_valid_o(rd_data_valid_o),
        .out_ready_i(rd_data_ready_i),
        .out_data_o(skid_out)
    );
endmodule

// >>> sim/input_capture_channels_props.sv
// Concurrent checks on the ports of the capture unit.
module input_capture_channels_props (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [capture_pkg::NUM_CHANNELS-1:0][capture_pkg::CTRL_W-1:0]
        channel_control_word_i,
    input wire logic cpu_idle_i,
    input wire logic cpu_sleep_i,
    input wire logic [capture_pkg::NUM_CHANNELS-1:0] channel_interrupt_enable_i,
    input wire logic rd_valid_i,
    input wire logic [capture_pkg::CHAN_W-1:0] rd_chan_i,
    input wire logic rd_ready_o,
    input wire logic rd_data_valid_o,
    input wire logic [capture_pkg::TIMER_W-1:0] rd_data_o,
    input wire logic [capture_pkg::CHAN_W-1:0] rd_data_chan_o,
    input wire logic rd_data_ready_i,
    input wire logic [capture_pkg::NUM_CHANNELS-1:0] buffer_not_empty_flag_o,
    input wire logic [capture_pkg::NUM_CHANNELS-1:0] capture_overflow_flag_o,
    input wire logic wake_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import capture_pkg::*;
    // Every check runs on the system clock and rests during reset.
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    // A request taken while the output is empty shows its channel one cycle later.
    property p_read_answer;
        rd_valid_i && rd_ready_o && !rd_data_valid_o |=>
            rd_data_valid_o && rd_data_chan_o == $past(rd_chan_i);
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read word late");
    // A stalled word must not change under the receiver.
    property p_hold_stall;
        rd_data_valid_o && !rd_data_ready_i |=>
            rd_data_valid_o && $stable(rd_data_o) && $stable(rd_data_chan_o);
    endproperty
    a_hold_stall: assert property (p_hold_stall) else $error("stalled word moved");
    // A wake pulse needs a low-power state and an enabled channel.
    property p_wake_cause;
        wake_o |-> $past(cpu_idle_i || cpu_sleep_i) && $past(|channel_interrupt_enable_i);
    endproperty
    a_wake_cause: assert property (p_wake_cause) else $error("wake without cause");
    // Per-channel relations between the buffer flags and their causes.
    for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_ch
        property p_sleep_store;
            $rose(buffer_not_empty_flag_o[c]) |-> !$past(cpu_sleep_i);
        endproperty
        a_sleep_store: assert property (p_sleep_store) else $error("stored in sleep");
        property p_off_store;
            $rose(buffer_not_empty_flag_o[c]) |->
                !($past(channel_control_word_i[c][2:0]) inside {3'h0, 3'h6});
        endproperty
        a_off_store: assert property (p_off_store) else $error("stored while off");
        property p_ovf_full;
            $rose(capture_overflow_flag_o[c]) |-> buffer_not_empty_flag_o[c];
        endproperty
        a_ovf_full: assert property (p_ovf_full) else $error("overflow when empty");
        property p_ovf_mode;
            $rose(capture_overflow_flag_o[c]) |->
                $past(channel_control_word_i[c][2:0]) != 3'h1;
        endproperty
        a_ovf_mode: assert property (p_ovf_mode) else $error("overflow every-edge");
        property p_bne_drop;
            $fell(buffer_not_empty_flag_o[c]) |-> $past(rd_valid_i && rd_ready_o && rd_chan_i == c);
        endproperty
        a_bne_drop: assert property (p_bne_drop) else $error("not-empty fell early");
    end
endmodule

// >>> sim/edge_source.sv
// Model of the external signals on the eight capture pins.
module edge_source (
    input wire logic mclk_i,
    output logic [7:0] pin_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pins rest low, as a pulled-down idle line does.
    initial pin_o = 8'h00;
    // Moves one pin after an edge and holds it past the synchroniser.
    task automatic drive(input int ch, input logic lvl);
        @(posedge mclk_i);
        pin_o[ch] <= lvl;
        repeat (8) @(posedge mclk_i);
    endtask
endmodule

// >>> sim/input_capture_channels_tb.sv
// Self-checking bench of the eight-channel input capture unit.
module input_capture_channels_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import capture_pkg::*;
    logic mclk_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic [7:0][15:0] ctl = '0;
    logic [15:0] tm1 = '0;
    logic [15:0] tm2 = '0;
    logic tm_on = 1'h1;
    logic idle = 1'h0;
    logic slp = 1'h0;
    logic [7:0] ie = '0;
    logic [7:0] evc = '0;
    logic [7:0] ovc = '0;
    logic rd_vld = 1'h0;
    logic [2:0] rd_ch = '0;
    logic rd_rdy = 1'h0;
    logic [7:0] pin;
    logic rdy;
    logic dv;
    logic [15:0] dat;
    logic [2:0] dch;
    logic [7:0] bne;
    logic [7:0] ovf;
    logic [7:0] evf;
    logic wake;
    logic [7:0][15:0] sw;
    logic [15:0] q [8][$];
    bit ovm [8];
    bit blk [8];
    logic [2:0] md [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
    int bad_count = 0;
    int n_compared = 0;
    int wake_n = 0;
    int ch = 0;
    // System clock of 100 ns period.
    initial begin
        forever #50 mclk_i = ~mclk_i;
    end
    edge_source src_i (.mclk_i(mclk_i), .pin_o(pin));
    input_capture_channels input_capture_channels_i (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .cap_pin_i(pin), .channel_control_word_i(ctl),
        .first_shared_timer_i(tm1), .second_shared_timer_i(tm2), .first_timer_on_i(tm_on),
        .second_timer_on_i(tm_on), .cpu_idle_i(idle), .cpu_sleep_i(slp),
        .channel_interrupt_enable_i(ie), .event_flag_clr_i(evc), .overflow_clr_i(ovc),
        .rd_valid_i(rd_vld), .rd_chan_i(rd_ch), .rd_ready_o(rdy), .rd_data_valid_o(dv),
        .rd_data_o(dat), .rd_data_chan_o(dch), .rd_data_ready_i(rd_rdy),
        .buffer_not_empty_flag_o(bne), .capture_overflow_flag_o(ovf),
        .channel_event_flag_o(evf), .channel_status_word_o(sw), .wake_o(wake));
    // Counts wake pulses once outputs have settled.
    always @(negedge mclk_i) begin
        if (wake === 1'h1) wake_n++;
    end
    task automatic end_of_test();
        if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Bounds every wait so a hang ends the run.
    task automatic lim(inout int t);
        t++;
        if (t > 200) begin
            bad_count++;
            end_of_test();
        end
    endtask
    // Switches the channel off, then sets the new control word.
    task automatic cfg(input logic [2:0] m, input logic ts, input logic [1:0] e, input logic sd);
        @(posedge mclk_i);
        ctl[ch] <= '0;
        @(posedge mclk_i);
        ctl[ch] <= {2'h0, sd, 5'h00, ts, e, 2'h0, m};
        repeat (2) @(posedge mclk_i);
    endtask
    task automatic clr();
        @(posedge mclk_i);
        evc[ch] <= 1'h1;
        ovc[ch] <= 1'h1;
        @(posedge mclk_i);
        evc <= '0;
        ovc <= '0;
        ovm[ch] = 1'h0;
    endtask
    task automatic power(input logic s, input logic i, input logic on);
        @(posedge mclk_i);
        slp <= s;
        idle <= i;
        tm_on <= on;
        ie <= 8'($urandom) | (8'h01 << ch);
    endtask
    // Predicts whether the n-th edge of level lvl is stored under mode m.
    function automatic logic cap_exp(input logic [2:0] m, input logic lvl, input int n);
        logic f;
        f = m == 3'h1 || (m == 3'h2 && !lvl) || ((m == 3'h3 || m == 3'h7) && lvl);
        f = f || (lvl && (m == 3'h4 && n % 4 == 0 || m == 3'h5 && n % 16 == 0));
        return f && !slp && (!idle || tm_on && !ctl[ch][13] && m != 3'h7);
    endfunction
    // One pin edge under fresh timer counts; the model predicts the buffer.
    task automatic pin_edge(input logic lvl, input int n);
        logic [2:0] m;
        logic f;
        @(posedge mclk_i);
        m = ctl[ch][2:0];
        f = cap_exp(m, lvl, n);
        tm1 <= 16'($urandom);
        tm2 <= 16'($urandom);
        src_i.drive(ch, lvl);
        if (f && !blk[ch] && q[ch].size() == 4 && m != 3'h1) begin
            ovm[ch] = 1'h1;
            blk[ch] = 1'h1;
        end else if (f && !blk[ch] && q[ch].size() < 4) begin
            q[ch].push_back(ctl[ch][7] ? tm1 : tm2);
        end
        @(negedge mclk_i);
        check("not_empty", 16'(bne[ch]), 16'(q[ch].size() != 0));
        check("overflow", 16'(ovf[ch]), 16'(ovm[ch]));
        check("status", sw[ch], {ctl[ch][15:5], ovm[ch], q[ch].size() != 0, ctl[ch][2:0]});
    endtask
    task automatic pulse(input int n);
        pin_edge(1'h1, n);
        pin_edge(1'h0, n);
    endtask
    // Takes n requests with the receiver stalled, then collects under random stalls.
    task automatic rd(input int n);
        int k;
        int t;
        k = 0;
        t = 0;
        @(posedge mclk_i);
        rd_rdy <= 1'h0;
        rd_vld <= 1'h1;
        rd_ch <= 3'(ch);
        while (k < n) begin
            @(negedge mclk_i);
            if (rdy === 1'h1) k++;
            @(posedge mclk_i);
            lim(t);
        end
        rd_vld <= 1'h0;
        @(negedge mclk_i);
        check("ready", 16'(rdy), 16'(n < 2));
        k = 0;
        while (k < n) begin
            @(posedge mclk_i);
            rd_rdy <= 1'($urandom);
            @(negedge mclk_i);
            if (dv === 1'h1 && rd_rdy) begin
                check("word", dat, q[ch].pop_front());
                check("chan", 16'(dch), 16'(ch));
                k++;
            end
            lim(t);
        end
        if (q[ch].size() == 0) blk[ch] = 1'h0;
    endtask
    task automatic drain();
        while (q[ch].size() > 0) rd(q[ch].size() > 1 ? 2 : 1);
    endtask
    // Main sequence of scenarios.
    initial begin
        void'($urandom(83));
        repeat (6) @(posedge mclk_i);
        rst_n_i <= 1'h1;
        @(negedge mclk_i);
        check("ready", 16'(rdy), 16'h0001);
        check("not_empty", 16'(bne), 16'h0000);
        foreach (md[i]) begin
            ch = $urandom_range(7);
            cfg(md[i], 1'($urandom), 2'h0, 1'h0);
            pulse(1);
            drain();
        end
        ch = $urandom_range(7);
        cfg(3'h4, 1'h0, 2'h0, 1'h0);
        for (int j = 1; j <= 2; j++) pulse(j);
        cfg(3'h4, 1'h1, 2'h0, 1'h0);
        for (int j = 1; j <= 4; j++) pulse(j);
        drain();
        cfg(3'h5, 1'h0, 2'h0, 1'h0);
        for (int j = 1; j <= 16; j++) pulse(j);
        drain();
        cfg(3'h3, 1'h1, 2'h0, 1'h0);
        for (int j = 1; j <= 5; j++) pulse(j);
        rd(2);
        rd(1);
        pulse(6);
        rd(1);
        pulse(7);
        drain();
        clr();
        @(negedge mclk_i);
        check("overflow", 16'(ovf[ch]), 16'h0000);
        cfg(3'h1, 1'h0, 2'h3, 1'h0);
        clr();
        pin_edge(1'h1, 1);
        check("event", 16'(evf[ch]), 16'h0001);
        pin_edge(1'h0, 1);
        for (int j = 1; j <= 3; j++) pulse(j);
        drain();
        cfg(3'h3, 1'h0, 2'h1, 1'h0);
        clr();
        pulse(1);
        check("event", 16'(evf[ch]), 16'h0000);
        pulse(2);
        check("event", 16'(evf[ch]), 16'h0001);
        drain();
        for (int p = 0; p < 2; p++) begin
            cfg(3'h7, 1'h0, 2'h0, 1'h1);
            clr();
            power(p == 0, p == 1, 1'h0);
            wake_n = 0;
            pulse(1);
            check("event", 16'(evf[ch]), 16'h0001);
            check("wake", 16'(wake_n), 16'h0001);
            cfg(3'h3, 1'h0, 2'h0, 1'h1);
            clr();
            wake_n = 0;
            pulse(1);
            check("event", 16'(evf[ch]), 16'h0000);
            check("wake", 16'(wake_n), 16'h0000);
            power(1'h0, 1'h0, 1'h1);
        end
        // Idle with the timer running and no stop keeps full capture function.
        power(1'h0, 1'h1, 1'h1);
        cfg(3'h3, 1'h1, 2'h0, 1'h0);
        clr();
        wake_n = 0;
        pulse(1);
        check("event", 16'(evf[ch]), 16'h0001);
        check("wake", 16'(wake_n), 16'h0001);
        drain();
        power(1'h0, 1'h0, 1'h1);
        // A reset in mid-run must clear a half-counted prescaler.
        cfg(3'h4, 1'h0, 2'h0, 1'h0);
        for (int j = 1; j <= 2; j++) pulse(j);
        @(posedge mclk_i);
        rst_n_i <= 1'h0;
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'h1;
        for (int j = 1; j <= 4; j++) pulse(j);
        drain();
        end_of_test();
    end
endmodule
bind input_capture_channels input_capture_channels_props props_i (.mclk_i, .rst_n_i,
    .channel_control_word_i, .cpu_idle_i, .cpu_sleep_i, .channel_interrupt_enable_i,
    .rd_valid_i, .rd_chan_i, .rd_ready_o, .rd_data_valid_o, .rd_data_o, .rd_data_chan_o,
    .rd_data_ready_i, .buffer_not_empty_flag_o, .capture_overflow_flag_o, .wake_o);
